//--- rtl/aopc_top.sv
// Output disable and power-down control around the conversion pipeline
`timescale 1ns/1ns
module aopc_top
	import aopc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Pin controls, asynchronous to clk_in
	input wire logic out_disable_in,
	input wire logic power_down_pin_in,
	// Quantiser result, offset binary
	input wire logic [DATA_W-1:0] sample_in,
	// Data pins
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_out,
	// Status
	output logic low_power_out,
	output logic data_valid_out,
	output logic recovering_out
);
	typedef struct packed {
		logic [1:0] dis_sync;
		logic [1:0] pd_sync;
		aopc_pm_t pm;
		logic [RCNT_W-1:0] rcnt;
		logic [DATA_W-1:0] dout;
		logic dvalid;
	} aopc_st_t;

	aopc_st_t st_r;
	aopc_st_t st_nxt;
	logic pd_s;
	logic dis_s;

	aopc_pipe_if pif ();

	aopc_pipe u_pipe (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.p(pif.pipe)
	);

	assign pd_s = st_r.pd_sync[1];
	assign dis_s = st_r.dis_sync[1];
	assign pif.sample = sample_in;
	// Flush held while the synchronised power-down pin is high so nothing stale reappears
	assign pif.flush = pd_s;

	always_comb begin
		st_nxt = st_r;
		st_nxt.dis_sync = {st_r.dis_sync[0], out_disable_in};
		st_nxt.pd_sync = {st_r.pd_sync[0], power_down_pin_in};
		unique case (st_r.pm)
			PM_RUN: begin
				if (pd_s) begin
					st_nxt.pm = PM_DOWN;
				end
			end
			PM_DOWN: begin
				if (!pd_s) begin
					st_nxt.pm = PM_RECOVER;
					st_nxt.rcnt = RECOVER_CNT;
				end
			end
			PM_RECOVER: begin
				if (pd_s) begin
					st_nxt.pm = PM_DOWN;
				end else if (st_r.rcnt <= 4'h1) begin
					st_nxt.pm = PM_RUN;
					st_nxt.rcnt = '0;
				end else begin
					st_nxt.rcnt = st_r.rcnt - 4'h1;
				end
			end
		endcase
		// Output register loads every clock; holds MID_CODE with valid low in power down
		if (st_r.pm == PM_DOWN) begin
			st_nxt.dout = MID_CODE;
			st_nxt.dvalid = 1'b0;
		end else begin
			st_nxt.dout = pif.word;
			st_nxt.dvalid = pif.word_valid && (st_r.pm == PM_RUN) && !pd_s;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r.dis_sync <= 2'h3;
			st_r.pd_sync <= 2'h0;
			st_r.pm <= PM_RUN;
			st_r.rcnt <= '0;
			st_r.dout <= ZERO_WORD;
			st_r.dvalid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign data_out = st_r.dout;
	// Enable high drives pins; low releases them
	assign data_oe_out = !dis_s;
	assign low_power_out = (st_r.pm == PM_DOWN);
	assign data_valid_out = st_r.dvalid && !dis_s;
	assign recovering_out = (st_r.pm == PM_RECOVER);
endmodule : aopc_top

//--- rtl/aopc_pkg.sv
// Constants and types for the converter output and power-down control
package aopc_pkg;
	localparam int DATA_W = 11;
	localparam int LATENCY = 6;
	localparam int CLK_PERIOD_NS = 50;
	localparam int RECOVER_NS = 300;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCNT_W = 4;
	localparam logic [RCNT_W-1:0] RECOVER_CNT = RCNT_W'(RECOVER_CYC);
	localparam logic [DATA_W-1:0] MID_CODE = 11'h400;
	localparam logic [DATA_W-1:0] ZERO_WORD = 11'h000;
	typedef enum logic [1:0] {
		PM_RUN,
		PM_DOWN,
		PM_RECOVER
	} aopc_pm_t;
endpackage : aopc_pkg

//--- rtl/aopc_pipe_if.sv
// Carrier between control and conversion pipeline
`timescale 1ns/1ns
interface aopc_pipe_if;
	import aopc_pkg::*;
	logic [DATA_W-1:0] sample;
	logic flush;
	logic [DATA_W-1:0] word;
	logic word_valid;
	modport ctrl (output sample, output flush, input word, input word_valid);
	modport pipe (input sample, input flush, output word, output word_valid);
endinterface : aopc_pipe_if

//--- rtl/aopc_pipe.sv
// Fixed-latency conversion pipeline with per-stage valid
`timescale 1ns/1ns
module aopc_pipe
	import aopc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Pipeline carrier
	aopc_pipe_if.pipe p
);
	typedef struct packed {
		logic [LATENCY-1:0][DATA_W-1:0] data;
		logic [LATENCY-1:0] valid;
	} aopc_pipe_st_t;

	aopc_pipe_st_t st_r;
	aopc_pipe_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Shifts on every clock, independent of output enable
		st_nxt.data = {st_r.data[LATENCY-2:0], p.sample};
		st_nxt.valid = {st_r.valid[LATENCY-2:0], 1'b1};
		if (p.flush) begin
			st_nxt.valid = '0;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign p.word = st_r.data[LATENCY-1];
	assign p.word_valid = st_r.valid[LATENCY-1];
endmodule : aopc_pipe

//--- verif/aopc_sva.sv
// Assertions on the disable and power-down pins
`timescale 1ns/1ns
module aopc_sva
	import aopc_pkg::*;
(
	// Watched top ports
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic out_disable_in,
	input wire logic power_down_pin_in,
	input wire logic [DATA_W-1:0] sample_in,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic data_oe_out,
	input wire logic low_power_out,
	input wire logic data_valid_out,
	input wire logic recovering_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_oe_hiz: assert property (out_disable_in [*3] |-> !data_oe_out) else $error("hiz");
	a_oe_drive: assert property (!out_disable_in [*3] |-> data_oe_out) else $error("drv");
	a_pd_enter: assert property (power_down_pin_in [*4] |-> low_power_out) else $error("pd");
	a_pd_quiet: assert property (low_power_out |-> !data_valid_out) else $error("pdv");
	a_pd_flush: assert property ($rose(low_power_out) |-> !data_valid_out [*8]) else $error("fl");
	a_rec_len: assert property ($fell(low_power_out) |-> recovering_out [*6]) else $error("rec");
	a_word_lat: assert property (data_valid_out |-> data_out == $past(sample_in, 7))
		else $error("lat");
	a_valid_on: assert property (data_valid_out |-> data_oe_out && !recovering_out)
		else $error("val");
endmodule : aopc_sva
bind aopc_top aopc_sva u_sva (.*);

//--- verif/aopc_cap.sv
// Capture logic model for converter words
`timescale 1ns/1ns
module aopc_cap
	import aopc_pkg::*;
(
	// Converter side
	input wire logic clk_in,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic valid_in,
	input wire logic recovering_in,
	// Captured word
	output logic [DATA_W-1:0] word_out,
	output logic valid_out
);
	always_ff @(posedge clk_in) begin
		word_out <= data_in;
		valid_out <= valid_in && !recovering_in;
	end
endmodule : aopc_cap

//--- verif/aopc_top_tb_top.sv
// Testbench for the disable and power-down control
`timescale 1ns/1ns
module aopc_top_tb_top import aopc_pkg::*; ;
	logic clk_in = 1'b0;
	logic rn = 1'b0;
	logic dis = 1'b0;
	logic pd = 1'b0;
	logic [DATA_W-1:0] smp = '0;
	logic [DATA_W-1:0] dout, cw;
	logic oe, lp, dv, rec, cv;
	logic [DATA_W-1:0] q[$];
	int n_errors = 0;
	int cmp_count = 0;
	aopc_top dut (.clk_in(clk_in), .resetn_in(rn), .out_disable_in(dis),
		.power_down_pin_in(pd), .sample_in(smp), .data_out(dout), .data_oe_out(oe),
		.low_power_out(lp), .data_valid_out(dv), .recovering_out(rec));
	aopc_cap cap (.clk_in(clk_in), .data_in(dout), .valid_in(dv),
		.recovering_in(rec), .word_out(cw), .valid_out(cv));
	initial forever #25 clk_in = ~clk_in;
	task chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e, input string n);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task end_sim;
		$display("cmp %0d err %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task run(input int n);
		logic [DATA_W-1:0] v;
		repeat (n) begin
			@(posedge clk_in);
			v = DATA_W'($urandom);
			smp <= v;
			q.push_back(v);
		end
	endtask : run
	// Queue acts as a delay line matching pipe plus capture
	always @(negedge clk_in) begin
		if (q.size() > 9) void'(q.pop_front());
		if (cv === 1'b1 && q.size() == 9) chk(cw, q[0], "word");
	end
	initial begin
		void'($urandom(32'h4089));
		repeat (20) @(posedge clk_in);
		rn <= 1'b1;
		// Outputs looked at on the falling edge, clear of the launching edge
		run(20);
		@(negedge clk_in);
		chk(DATA_W'(oe), 11'h001, "oe");
		run(1);
		dis <= 1'b1;
		run(5);
		@(negedge clk_in);
		chk(DATA_W'(oe), 11'h000, "oe");
		run(1);
		dis <= 1'b0;
		run(4);
		@(negedge clk_in);
		chk(DATA_W'(dv), 11'h001, "dv");
		run(1);
		pd <= 1'b1;
		run(6);
		@(negedge clk_in);
		chk(DATA_W'(lp), 11'h001, "lp");
		chk(dout, MID_CODE, "pdw");
		run(1);
		pd <= 1'b0;
		run(4);
		@(negedge clk_in);
		chk(DATA_W'(rec), 11'h001, "rec");
		for (int i = 0; i < 40 && dv !== 1'b1; i++) begin
			run(1);
			@(negedge clk_in);
		end
		chk(DATA_W'(dv), 11'h001, "dv");
		run(20);
		end_sim();
	end
endmodule : aopc_top_tb_top
